// *** lan_cfg_pkg.sv ***
/*
 * package for the mac configuration parameter block: register offsets,
 * field positions and reset defaults of the loaded operating parameters.
 * assumes a single 10 MHz system clock and an avalon-mm register slave.
 */
package lan_cfg_pkg;

   // ******************************************************************
   // register byte addresses (one 32-bit word each)
   // ******************************************************************
   localparam logic [4:0] OFS_W0   = 5'h00; // bytes 6-7: count, fifo limit
   localparam logic [4:0] OFS_W1   = 5'h04; // bytes 8-9
   localparam logic [4:0] OFS_W2   = 5'h08; // bytes 10-11
   localparam logic [4:0] OFS_W3   = 5'h0C; // bytes 12-13
   localparam logic [4:0] OFS_W4   = 5'h10; // bytes 14-15
   localparam logic [4:0] OFS_W5   = 5'h14; // byte 16
   localparam logic [4:0] OFS_CTL  = 5'h18; // apply / soft reset
   localparam logic [4:0] OFS_STAT = 5'h1C; // decoded state

   // ******************************************************************
   // field positions
   // ******************************************************************
   localparam int CNT_LO     = 0;
   localparam int FIFO_LO    = 8;
   localparam int RDY_BIT    = 6;
   localparam int SAVBF_BIT  = 7;
   localparam int ALEN_LO    = 8;
   localparam int ALLOC_BIT  = 11;
   localparam int PREAM_LO   = 12;
   localparam int ILPB_BIT   = 14;
   localparam int ELPB_BIT   = 15;
   localparam int LPRI_LO    = 0;
   localparam int ACR_LO     = 4;
   localparam int BOF_BIT    = 7;
   localparam int IFS_LO     = 8;
   localparam int SLOTL_LO   = 0;
   localparam int SLOTH_LO   = 8;
   localparam int RETRY_LO   = 12;
   localparam int TONO_BIT   = 3;
   localparam int CRC16_BIT  = 5;
   localparam int MINF_LO    = 0;
   localparam int CTL_APPLY  = 0;
   localparam int CTL_SRST   = 1;

   // ******************************************************************
   // reset defaults, each word as held in the parameter block
   // ******************************************************************
   localparam logic [3:0]  MIN_BYTE_COUNT = 4'h4;
   localparam logic [2:0]  ALEN_ALIAS     = 3'h7;
   localparam logic [15:0] DEF_W0 = 16'h080C; // 12 bytes, fifo limit 8
   localparam logic [15:0] DEF_W1 = 16'h2600; // 8-byte preamble, 6-byte addr
   localparam logic [15:0] DEF_W2 = 16'h6000; // gap 96 bits
   localparam logic [15:0] DEF_W3 = 16'hF200; // slot 512, 15 retries
   localparam logic [15:0] DEF_W4 = 16'h0000;
   localparam logic [15:0] DEF_W5 = 16'h0040; // 64-byte frame minimum

   // ******************************************************************
   // loopback modes
   // ******************************************************************
   typedef enum logic [2:0] {
      LPB_NONE  = 3'b001,
      LPB_INNER = 3'b010,
      LPB_OUTER = 3'b100
   } loopback_t;

endpackage : lan_cfg_pkg

// *** lan_mac_config_params.sv ***
/*
 * operating parameter store of the lan mac: software stages the parameter
 * block words over avalon-mm, an apply strobe loads them (as far as the
 * byte count reaches) into the live set that the serial side reads.
 * assumes a synchronous bus master on sys_clk; the serial unit samples
 * the decoded outputs as static levels between frames.
 */
// Implementation choices: the Avalon-MM register port and the register offsets.
// Functional notes
// - keep_bad_frames low discards bad received frames, high keeps them.
// - address length from three-bit field, value 7 acts as 0.
// - placement 0 keeps address apart, device inserts source address.
// - placement 1 puts address in data buffers, no source insertion.
// - bit 14 inner loopback, only bit 15 outer, both gives inner.
// - backoff select 0 standard exponential, 1 alternate method.
// - without-carrier 0 stops on carrier loss, 1 keeps transmitting.
// - crc type 0 selects 32-bit, 1 selects 16-bit ccitt polynomial.
// - minimum frame bytes from bits 0-7 of byte 16.
// - reset loads every parameter with its 802.3-compatible default.
// - defaults: 64-byte frame, 96-bit gap, 512-bit slot, 15 retries.
// - byte count bits 0-3, values below 4 taken as 4.
`timescale 1ns/10ps
module lan_mac_config_params (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic [4:0]              avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   output logic                         keep_bad_frames,
   output logic [2:0]                   addr_length,
   output logic                         addr_len_placement,
   output logic                         insert_source_addr,
   output logic [4:0]                   preamble_size,
   output lan_cfg_pkg::loopback_t       loopback_mode,
   output logic                         backoff_method_select,
   output logic                         transmit_without_carrier,
   output logic                         crc_is_16,
   output logic [7:0]                   minimum_frame_bytes,
   output logic [7:0]                   gap_between_frames,
   output logic [10:0]                  slot_time,
   output logic [3:0]                   retry_limit
);

   // ******************************************************************
   // staged and live parameter words
   // ******************************************************************
   logic [15:0] stage_q [6];
   logic [15:0] live_q  [6];
   logic        ack_q;
   logic [31:0] rdata_q;

   function automatic logic [15:0] def_word(input int idx);
      case (idx)
         0:       def_word = lan_cfg_pkg::DEF_W0;
         1:       def_word = lan_cfg_pkg::DEF_W1;
         2:       def_word = lan_cfg_pkg::DEF_W2;
         3:       def_word = lan_cfg_pkg::DEF_W3;
         4:       def_word = lan_cfg_pkg::DEF_W4;
         default: def_word = lan_cfg_pkg::DEF_W5;
      endcase
   endfunction : def_word

   // byte lane merge for a 16-bit word in the low half
   function automatic logic [15:0] merge(input logic [15:0] old_w,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      merge = {be[1] ? wd[15:8] : old_w[15:8], be[0] ? wd[7:0] : old_w[7:0]};
   endfunction : merge

   // ******************************************************************
   // bus decode: one wait cycle, then the answer
   // ******************************************************************
   wire       access     = avs_read | avs_write;
   wire       take       = access & ack_q;
   wire [2:0] word_idx   = avs_address[4:2];
   wire       is_stage   = (word_idx < 3'h6);
   wire       wr_stage   = take & avs_write & is_stage;
   wire       wr_ctl     = take & avs_write & (avs_address == lan_cfg_pkg::OFS_CTL);
   wire       apply      = wr_ctl & avs_byteenable[0] & avs_writedata[lan_cfg_pkg::CTL_APPLY];
   wire       soft_rst   = wr_ctl & avs_byteenable[0] & avs_writedata[lan_cfg_pkg::CTL_SRST];

   assign avs_waitrequest = access & ~ack_q;
   assign avs_readdata    = rdata_q;

   wire [3:0] raw_cnt    = stage_q[0][lan_cfg_pkg::CNT_LO +: 4];
   wire [3:0] eff_cnt    = (raw_cnt < lan_cfg_pkg::MIN_BYTE_COUNT) ?
                           lan_cfg_pkg::MIN_BYTE_COUNT : raw_cnt;

   // byte pos counted from the count byte itself loads only if the count
   // covers it; the count includes its own byte
   function automatic logic byte_in(input logic [3:0] cnt, input int pos);
      byte_in = ({1'b0, cnt} > 5'(pos));
   endfunction : byte_in

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access & ~ack_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || soft_rst) begin
         for (int i = 0; i < 6; i++) begin
            stage_q[i] <= def_word(i);
            live_q[i]  <= def_word(i);
         end
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (wr_stage && word_idx == 3'(i)) begin
               stage_q[i] <= merge(stage_q[i], avs_writedata, avs_byteenable);
            end
            if (apply) begin
               if (byte_in(eff_cnt, 2 * i)) begin
                  live_q[i][7:0] <= stage_q[i][7:0];
               end
               if (byte_in(eff_cnt, 2 * i + 1)) begin
                  live_q[i][15:8] <= stage_q[i][15:8];
               end
            end
         end
      end
   end

   // ******************************************************************
   // read path
   // ******************************************************************
   wire [31:0] stat_word = {16'h0000, 5'h00, loopback_mode, crc_is_16,
                            transmit_without_carrier, backoff_method_select,
                            insert_source_addr, addr_len_placement,
                            keep_bad_frames, eff_cnt[1:0]};
   wire [31:0] rd_mux    = is_stage ? {16'h0000, stage_q[word_idx]} :
                           (avs_address == lan_cfg_pkg::OFS_STAT) ? stat_word :
                           32'h0000_0000;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         rdata_q <= rd_mux;
      end
   end

   // ******************************************************************
   // decoded parameters for the serial side
   // ******************************************************************
   wire [1:0] pre_code = live_q[1][lan_cfg_pkg::PREAM_LO +: 2];
   wire [2:0] alen_raw = live_q[1][lan_cfg_pkg::ALEN_LO +: 3];
   wire       lp_in    = live_q[1][lan_cfg_pkg::ILPB_BIT];
   wire       lp_ex    = live_q[1][lan_cfg_pkg::ELPB_BIT];

   assign keep_bad_frames          = live_q[1][lan_cfg_pkg::SAVBF_BIT];
   assign addr_length              = (alen_raw == lan_cfg_pkg::ALEN_ALIAS) ? 3'h0 : alen_raw;
   assign addr_len_placement       = live_q[1][lan_cfg_pkg::ALLOC_BIT];
   assign insert_source_addr       = ~addr_len_placement;
   assign preamble_size            = 5'(5'h02 << pre_code);
   assign loopback_mode            = lp_in ? lan_cfg_pkg::LPB_INNER :
                                     lp_ex ? lan_cfg_pkg::LPB_OUTER : lan_cfg_pkg::LPB_NONE;
   assign backoff_method_select    = live_q[2][lan_cfg_pkg::BOF_BIT];
   assign transmit_without_carrier = live_q[4][lan_cfg_pkg::TONO_BIT];
   assign crc_is_16                = live_q[4][lan_cfg_pkg::CRC16_BIT];
   assign minimum_frame_bytes      = live_q[5][lan_cfg_pkg::MINF_LO +: 8];
   assign gap_between_frames       = live_q[2][lan_cfg_pkg::IFS_LO +: 8];
   assign slot_time                = {live_q[3][lan_cfg_pkg::SLOTH_LO +: 3],
                                      live_q[3][lan_cfg_pkg::SLOTL_LO +: 8]};
   assign retry_limit              = live_q[3][lan_cfg_pkg::RETRY_LO +: 4];

endmodule : lan_mac_config_params

// *** lan_mac_config_params_chk.sv ***
/* checker: port relations of the mac parameter store.
   assumes bind onto the design top, one clock domain. */
`timescale 1ns/10ps
module lan_mac_config_params_chk (
   input wire logic                   sys_clk,
   input wire logic                   rst_n,
   input wire logic                   avs_write,
   input wire logic                   avs_waitrequest,
   input wire logic                   keep_bad_frames,
   input wire logic [2:0]             addr_length,
   input wire logic                   addr_len_placement,
   input wire logic                   insert_source_addr,
   input wire logic [4:0]             preamble_size,
   input wire lan_cfg_pkg::loopback_t loopback_mode,
   input wire logic [7:0]             minimum_frame_bytes,
   input wire logic [10:0]            slot_time,
   input wire logic [3:0]             retry_limit
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_alen; addr_length != 3'h7; endproperty
   a_alen: assert property (p_alen) else $error("address length shows 7");
   property p_ins; insert_source_addr == !addr_len_placement; endproperty
   a_ins: assert property (p_ins) else $error("source insert wrong");
   property p_loop; $onehot(loopback_mode); endproperty
   a_loop: assert property (p_loop) else $error("loopback not one-hot");
   property p_pre; preamble_size inside {5'h02, 5'h04, 5'h08, 5'h10}; endproperty
   a_pre: assert property (p_pre) else $error("preamble size illegal");
   property p_dfa; $rose(rst_n) |-> minimum_frame_bytes == 8'h40
      && slot_time == 11'h200 && retry_limit == 4'hF; endproperty
   a_dfa: assert property (p_dfa) else $error("timing defaults wrong");
   property p_dfb; $rose(rst_n) |-> preamble_size == 5'h08
      && addr_length == 3'h6 && !keep_bad_frames; endproperty
   a_dfb: assert property (p_dfb) else $error("frame defaults wrong");
   // only a bus write may move the live set
   property p_hold; !$past(avs_write) |-> $stable(keep_bad_frames)
      && $stable(minimum_frame_bytes); endproperty
   a_hold: assert property (p_hold) else $error("live value moved");
   property p_wait; $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("wait cycle wrong");
endmodule : lan_mac_config_params_chk
bind lan_mac_config_params lan_mac_config_params_chk chk (.*);

// *** lan_serial_model.sv ***
/* serial side model: turns the live crc type into the crc width on the line.
   assumes static levels between frames. */
`timescale 1ns/10ps
module lan_serial_model (
   input wire logic       crc_is_16,
   output logic     [5:0] crc_bits
);
   // crc width used on the line
   assign crc_bits = crc_is_16 ? 6'h10 : 6'h20;
endmodule : lan_serial_model

// *** lan_mac_config_params_tb.sv ***
/* bench: stages parameter words over avalon-mm and checks the live set.
   assumes one wait cycle per access, byte lanes 0-1 used. */
`timescale 1ns/10ps
module lan_mac_config_params_tb;
   logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [4:0]  avs_address, preamble_size;
   logic [31:0] avs_writedata, avs_readdata, rd_q;
   logic [3:0]  avs_byteenable, retry_limit;
   logic        keep_bad_frames, addr_len_placement, insert_source_addr;
   logic        backoff_method_select, transmit_without_carrier, crc_is_16;
   logic [2:0]  addr_length;
   logic [5:0]  crc_bits;
   logic [7:0]  minimum_frame_bytes, gap_between_frames;
   logic [10:0] slot_time;
   int          n_mismatch, checked;
   lan_cfg_pkg::loopback_t loopback_mode;
   lan_cfg_pkg::loopback_t lp_x [4] = '{lan_cfg_pkg::LPB_NONE, lan_cfg_pkg::LPB_INNER,
                                        lan_cfg_pkg::LPB_OUTER, lan_cfg_pkg::LPB_INNER};
   lan_mac_config_params dut (.*);
   lan_serial_model model (.*);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // waitrequest and readdata are read at the rising edge, before it updates them
   task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 40) begin
         n_mismatch++;
      end
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : acc
   task automatic dflt;
      repeat (2) @(negedge sys_clk);
      chk("min frame", minimum_frame_bytes, 8'h40);
      chk("gap", gap_between_frames, 8'h60);
      chk("slot", slot_time, 11'h200);
      chk("retries", retry_limit, 4'hF);
      chk("preamble", preamble_size, 5'h08);
      chk("addr len", addr_length, 3'h6);
      chk("loop", loopback_mode, lan_cfg_pkg::LPB_NONE);
      chk("crc bits", crc_bits, 6'h20);
      chk("flags", {keep_bad_frames, addr_len_placement, backoff_method_select,
                    transmit_without_carrier, crc_is_16, insert_source_addr}, 6'h01);
   endtask : dflt
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (3000) @(posedge sys_clk);
      n_mismatch++;
      end_sim();
   end
   initial begin
      {n_mismatch, checked, rst_n, avs_read, avs_write} = '0;
      {avs_address, avs_writedata, avs_byteenable} = {5'h00, 32'h0000_0000, 4'h3};
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      dflt();
      $display("test reset defaults done");
      acc(1'b1, 5'h00, 32'hFFFF_080C);
      acc(1'b1, 5'h04, 32'h0000_CF80);
      acc(1'b1, 5'h08, 32'h0000_2080);
      acc(1'b1, 5'h0C, 32'h0000_53FF);
      acc(1'b1, 5'h10, 32'h0000_0028);
      acc(1'b1, 5'h14, 32'h0000_007F);
      acc(1'b1, 5'h18, 32'h0000_0001);
      repeat (2) @(negedge sys_clk);
      chk("keep bad", keep_bad_frames, 1'h1);
      chk("addr len", addr_length, 3'h0);
      chk("placement", {addr_len_placement, insert_source_addr}, 2'h2);
      chk("backoff", backoff_method_select, 1'h1);
      chk("no carrier", transmit_without_carrier, 1'h1);
      chk("crc bits", crc_bits, 6'h10);
      chk("min frame", minimum_frame_bytes, 8'h7F);
      chk("gap", gap_between_frames, 8'h20);
      chk("slot", slot_time, 11'h3FF);
      chk("retries", retry_limit, 4'h5);
      acc(1'b0, 5'h00, 32'h0000_0000);
      chk("word0 read", rd_q, 32'h0000_080C);
      acc(1'b0, 5'h1C, 32'h0000_0000);
      chk("status read", rd_q, 32'h0000_02EC);
      $display("test full load done");
      acc(1'b1, 5'h18, 32'h0000_0002);
      dflt();
      $display("test soft reset done");
      acc(1'b1, 5'h00, 32'h0000_0002);
      acc(1'b1, 5'h08, 32'h0000_0080);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 5'h04, {16'h0000, i[1:0], i[1:0], 12'h000});
         acc(1'b1, 5'h18, 32'h0000_0001);
         repeat (2) @(negedge sys_clk);
         chk("loop", loopback_mode, lp_x[i]);
         chk("preamble", preamble_size, 5'h02 << i);
         chk("backoff", backoff_method_select, 1'h0);
      end
      $display("test short count done");
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      dflt();
      $display("test second reset done");
      end_sim();
   end
endmodule : lan_mac_config_params_tb
